//--- src/bmc_pkg.sv
// Package: offsets, fields, reset values and types of the bus-management CSR access block
package bmc_pkg;

   // ****************************************
   // Register offsets (byte addresses)
   // ****************************************
   localparam logic [7:0] BMC_OFF_DATA = 8'h0C;
   localparam logic [7:0] BMC_OFF_COMPARE = 8'h10;
   localparam logic [7:0] BMC_OFF_CTRL = 8'h14;
   localparam logic [7:0] BMC_OFF_ROM_HDR = 8'h18;
   localparam logic [7:0] BMC_OFF_BUS_NAME = 8'h1C;
   localparam logic [7:0] BMC_OFF_IRQ_STATUS = 8'h24;
   localparam logic [7:0] BMC_OFF_IRQ_MASK = 8'h28;
   localparam logic [7:0] BMC_OFF_DATA_LOAD = 8'h2C;
   localparam logic [7:0] BMC_OFF_COMPARE_LOAD = 8'h30;
   localparam logic [7:0] BMC_OFF_RES_BASE = 8'h40;

   // ****************************************
   // Field positions and constants
   // ****************************************
   localparam int BMC_DONE_BIT = 31;
   localparam int BMC_SEL_W = 2;
   localparam int BMC_RES_NUM = 4;
   localparam int BMC_IRQ_W = 1;
   localparam int BMC_HDR_UPPER_LSB = 16;
   localparam logic [31:0] BMC_BUS_NAME_VALUE = 32'h31333934;
   localparam logic BMC_DONE_RESET = 1'b1;
   localparam logic [1:0] BMC_SEL_RESET = 2'h0;
   localparam logic [15:0] BMC_HDR_UPPER_RESET = 16'h0000;
   localparam logic [15:0] BMC_HDR_CRC_RESET = 16'h0000;
   localparam logic [31:0] BMC_RES_RESET = 32'h00000000;
   localparam logic [31:0] BMC_ZERO = 32'h00000000;

   // Resource select codes
   localparam logic [1:0] BMC_SEL_BUS_MGR_ID = 2'h0;
   localparam logic [1:0] BMC_SEL_BANDWIDTH = 2'h1;
   localparam logic [1:0] BMC_SEL_CHAN_HI = 2'h2;
   localparam logic [1:0] BMC_SEL_CHAN_LO = 2'h3;

   typedef enum logic [1:0] {
      BMC_IDLE,
      BMC_SWAP
   } bmc_state_t;

   typedef struct packed {
      bmc_state_t state;
      logic compare_swap_done;
      logic [1:0] resource_select;
      logic [31:0] config_rom_first_quadlet;
      logic crc_loaded;
      logic [31:0] swap_data;
      logic [31:0] swap_compare;
      logic [BMC_RES_NUM-1:0][31:0] resource;
      logic [31:0] prdata;
      logic irq_status;
      logic irq_mask;
      logic [31:0] last_old_value;
   } bmc_regs_t;

endpackage

//--- src/bmc_csr_access.sv
// Bus-management CSR compare-swap control, ROM header and bus name registers over APB
`timescale 1ns/1ns

// Function
// (RULE1) Done flag bit 31 set after swap
// (RULE2) Any control write clears done flag
// (RULE3) Control bits 30..2 read zero
// (RULE4) Select field picks one of four resources
// (RULE5) Software keeps header lengths valid when linked
// (RULE6) Software keeps header CRC valid when linked
// (RULE7) CRC field loaded from serial ROM
// (RULE8) Header upper half resets zero, all RW
// (RULE9) Header register feeds remote ROM quadlet
// (RULE10) Bus name register fixed read-only constant
// (RULE11) Data register holds swap value, read-only
// (RULE12) Compare register holds compare value
// (RULE13) Select write starts atomic compare-swap
module bmc_csr_access
   import bmc_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic clk_en,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic rom_present,
   input wire logic rom_crc_valid,
   input wire logic [15:0] rom_crc_value,
   input wire logic link_active_enable,
   output logic [31:0] rom_first_quadlet,
   output logic [31:0] bus_info_first_quadlet,
   output logic [1:0] resource_select,
   output logic [BMC_RES_NUM*32-1:0] resource_values,
   output logic irq
);

   bmc_regs_t r_reg;
   bmc_regs_t r_next;
   logic wr_en;
   logic rd_en;
   logic mapped;
   logic [31:0] rd_word;
   logic [31:0] ctrl_word;
   logic [31:0] cur_res;
   logic swap_hit;
   logic done_evt;

   // ****************************************
   // APB decode
   // ****************************************
   // Zero wait states: every access completes in its first access cycle
   assign pready = 1'b1;
   assign wr_en = clk_en & psel & penable & pwrite;
   assign rd_en = clk_en & psel & penable & ~pwrite;

   // Reserved bits of the control word are tied low
   always_comb begin
      ctrl_word = BMC_ZERO;                                          // RULE3
      ctrl_word[BMC_DONE_BIT] = r_reg.compare_swap_done;              // RULE1
      ctrl_word[BMC_SEL_W-1:0] = r_reg.resource_select;
   end

   // Currently selected resource, compared against the compare word
   assign cur_res = r_reg.resource[r_reg.resource_select];            // RULE4
   assign swap_hit = (cur_res == r_reg.swap_compare);

   // Read multiplexer and unmapped address detection
   always_comb begin
      mapped = 1'b1;
      rd_word = BMC_ZERO;
      unique case (paddr)
         BMC_OFF_DATA: rd_word = r_reg.swap_data;                     // RULE11
         BMC_OFF_COMPARE: rd_word = r_reg.swap_compare;               // RULE12
         BMC_OFF_CTRL: rd_word = ctrl_word;
         BMC_OFF_ROM_HDR: rd_word = r_reg.config_rom_first_quadlet;
         BMC_OFF_BUS_NAME: rd_word = BMC_BUS_NAME_VALUE;              // RULE10
         BMC_OFF_IRQ_STATUS: rd_word = {31'h00000000, r_reg.irq_status};
         BMC_OFF_IRQ_MASK: rd_word = {31'h00000000, r_reg.irq_mask};
         BMC_OFF_DATA_LOAD: rd_word = r_reg.swap_data;
         BMC_OFF_COMPARE_LOAD: rd_word = r_reg.swap_compare;
         BMC_OFF_RES_BASE: rd_word = r_reg.resource[0];
         BMC_OFF_RES_BASE + 8'h04: rd_word = r_reg.resource[1];
         BMC_OFF_RES_BASE + 8'h08: rd_word = r_reg.resource[2];
         BMC_OFF_RES_BASE + 8'h0C: rd_word = r_reg.resource[3];
         default: mapped = 1'b0;
      endcase
   end

   // Unmapped addresses answer with an error; writes to read-only words are ignored
   assign pslverr = psel & penable & ~mapped;

   // ****************************************
   // Next-state logic
   // ****************************************
   always_comb begin
      r_next = r_reg;
      done_evt = 1'b0;
      if (rd_en) begin
         r_next.prdata = rd_word;
      end
      // ROM CRC is taken once after reset, before software may overwrite it
      if (!r_reg.crc_loaded) begin
         if (!rom_present) begin
            r_next.crc_loaded = 1'b1;
         end else if (rom_crc_valid) begin
            r_next.config_rom_first_quadlet[BMC_HDR_UPPER_LSB-1:0] = rom_crc_value; // RULE7
            r_next.crc_loaded = 1'b1;
         end
      end
      // Swap runs in the cycle after the select write, so it is atomic
      unique case (r_reg.state)
         BMC_IDLE: begin
         end
         BMC_SWAP: begin
            if (swap_hit) begin
               r_next.resource[r_reg.resource_select] = r_reg.swap_data; // RULE13
            end
            r_next.last_old_value = cur_res;
            r_next.compare_swap_done = 1'b1;                          // RULE1
            done_evt = 1'b1;
            r_next.state = BMC_IDLE;
         end
         default: r_next.state = BMC_IDLE;
      endcase
      if (wr_en) begin
         unique case (paddr)
            BMC_OFF_CTRL: begin
               r_next.compare_swap_done = 1'b0;                       // RULE2
               if (pstrb[0]) begin
                  r_next.resource_select = pwdata[BMC_SEL_W-1:0];      // RULE4
                  r_next.state = BMC_SWAP;                            // RULE13
               end
            end
            BMC_OFF_ROM_HDR: begin
               for (int b = 0; b < 4; b++) begin
                  if (pstrb[b]) begin
                     r_next.config_rom_first_quadlet[b*8 +: 8] = pwdata[b*8 +: 8]; // RULE8
                  end
               end
               // A software write must not be overwritten by a late ROM load
               r_next.crc_loaded = 1'b1;
            end
            BMC_OFF_IRQ_STATUS: begin
               if (pstrb[0] && pwdata[0]) begin
                  r_next.irq_status = 1'b0;
               end
            end
            BMC_OFF_IRQ_MASK: begin
               if (pstrb[0]) begin
                  r_next.irq_mask = pwdata[0];
               end
            end
            BMC_OFF_DATA_LOAD: begin
               r_next.swap_data = pwdata;
            end
            BMC_OFF_COMPARE_LOAD: begin
               r_next.swap_compare = pwdata;
            end
            default: begin
            end
         endcase
      end
      // Set wins over a clear in the same cycle
      if (done_evt) begin
         r_next.irq_status = 1'b1;
      end
   end

   // ****************************************
   // State register
   // ****************************************
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         r_reg.state <= BMC_IDLE;
         r_reg.compare_swap_done <= BMC_DONE_RESET;
         r_reg.resource_select <= BMC_SEL_RESET;
         r_reg.config_rom_first_quadlet <= {BMC_HDR_UPPER_RESET, BMC_HDR_CRC_RESET}; // RULE8
         r_reg.crc_loaded <= 1'b0;
         r_reg.swap_data <= BMC_ZERO;
         r_reg.swap_compare <= BMC_ZERO;
         r_reg.resource <= {BMC_RES_NUM{BMC_RES_RESET}};
         r_reg.prdata <= BMC_ZERO;
         r_reg.irq_status <= 1'b0;
         r_reg.irq_mask <= 1'b0;
         r_reg.last_old_value <= BMC_ZERO;
      end else if (clk_en) begin
         r_reg <= r_next;
      end
   end

   // ****************************************
   // Outputs
   // ****************************************
   // Live word during a read access phase, last read word held otherwise
   assign prdata = (psel & penable & ~pwrite) ? rd_word : r_reg.prdata;
   assign rom_first_quadlet = r_reg.config_rom_first_quadlet;          // RULE9
   assign bus_info_first_quadlet = BMC_BUS_NAME_VALUE;                 // RULE10
   assign resource_select = r_reg.resource_select;
   assign resource_values = r_reg.resource;
   assign irq = r_reg.irq_status & r_reg.irq_mask;

endmodule

//--- testbench/bmc_csr_access_properties.sv
// Checker: timing properties on the CSR access block ports
`timescale 1ns/1ns
module bmc_csr_properties
   import bmc_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic clk_en,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic [31:0] rom_first_quadlet,
   input wire logic [31:0] bus_info_first_quadlet,
   input wire logic [1:0] resource_select
);
   // Completed access phases
   wire logic acc = psel && penable && pready && clk_en;
   wire logic ctrl_wr = acc && pwrite && paddr == 8'h14 && pstrb[0];
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   sequence ctrl_rd_s;
      acc && !pwrite && paddr == 8'h14;
   endsequence
   sequence swap_then_read_s;
      ctrl_wr ##[2:4] ctrl_rd_s;
   endsequence
   sel_update_a: assert property (ctrl_wr |=> resource_select == $past(pwdata[1:0])) else $error("sel bad");
   sel_hold_a: assert property ($changed(resource_select) |-> $past(ctrl_wr)) else $error("sel moved");
   done_set_a: assert property (swap_then_read_s |-> prdata[31]) else $error("done low");
   ctrl_resvd_a: assert property (ctrl_rd_s |-> prdata[30:2] == 29'h0) else $error("reserved set");
   name_port_a: assert property (bus_info_first_quadlet == 32'h31333934) else $error("name port");
   name_read_a: assert property (acc && !pwrite && paddr == 8'h1C |-> prdata == 32'h31333934) else $error("name rd");
   hdr_write_a: assert property (acc && pwrite && paddr == 8'h18 && pstrb == 4'hF
      |=> rom_first_quadlet == $past(pwdata)) else $error("hdr write");
   hdr_reset_a: assert property ($rose(presetn) |-> rom_first_quadlet[31:16] == 16'h0) else $error("hdr rst");
endmodule

bind bmc_csr_access bmc_csr_properties u_props (.pclk, .presetn, .clk_en, .psel, .penable, .pwrite, .paddr,
   .pwdata, .pstrb, .prdata, .pready, .rom_first_quadlet, .bus_info_first_quadlet, .resource_select);

//--- testbench/tb.sv
// Testbench: APB register sequences with expected values
`timescale 1ns/1ns
module tb
   import bmc_pkg::*;
;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq, err, clk_en;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata, rd, rom_first_quadlet, bus_info_first_quadlet;
   logic [3:0] pstrb;
   logic [1:0] resource_select;
   logic [127:0] resource_values;
   int err_total, checks_done;
   // CRC strobe follows reset so the load lands on the first live cycle
   bmc_csr_access dut (.pclk(pclk), .presetn(presetn), .clk_en(clk_en), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .rom_present(1'b1), .rom_crc_valid(presetn), .rom_crc_value(16'hBEEF),
      .link_active_enable(1'b1), .rom_first_quadlet(rom_first_quadlet),
      .bus_info_first_quadlet(bus_info_first_quadlet), .resource_select(resource_select),
      .resource_values(resource_values), .irq(irq));
   // 100 MHz clock
   initial begin
      pclk = 1'b0;
      forever #5 pclk = ~pclk;
   end
   // ****************************************
   // Bus tasks
   // ****************************************
   task automatic print_verdict();
      $display("checks %0d errors %0d", checks_done, err_total);
      if (err_total == 0 && checks_done > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask
   task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
      checks_done++;
      if (got !== exp) begin
         err_total++;
         $display("mismatch %s exp %h got %h", nm, exp, got);
      end
   endtask
   // Holds the request until pready is seen at an edge
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
      int n;
      n = 0;
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      pstrb <= s;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1) begin
         n++;
         if (n > 50) begin
            err_total++;
            print_verdict();
         end
         @(posedge pclk);
      end
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
      apb(1'b0, a, 32'h0, 4'h0);
      chk($sformatf("reg %h", a), rd, exp);
   endtask
   // Polls control until the swap reports done, bounded
   task automatic wait_done();
      int n;
      n = 0;
      rd = 32'h0;
      while (rd[31] !== 1'b1) begin
         n++;
         if (n > 20) begin
            err_total++;
            print_verdict();
         end
         apb(1'b0, 8'h14, 32'h0, 4'h0);
      end
   endtask
   // ****************************************
   // Main sequence
   // ****************************************
   initial begin
      {presetn, psel, penable, pwrite, paddr, pwdata, pstrb} = '0;
      clk_en = 1'b1;
      err_total = 0;
      checks_done = 0;
      repeat (20) @(posedge pclk);
      presetn <= 1'b1;
      rdchk(8'h14, 32'h80000000);
      rdchk(8'h18, 32'h0000BEEF);
      apb(1'b1, 8'h1C, 32'h0, 4'hF);
      rdchk(8'h1C, 32'h31333934);
      chk("bus info", bus_info_first_quadlet, 32'h31333934);
      // Header written with valid lengths and CRC while the link is enabled
      apb(1'b1, 8'h18, 32'hA5C31234, 4'hF);
      rdchk(8'h18, 32'hA5C31234);
      chk("rom", rom_first_quadlet, 32'hA5C31234);
      apb(1'b1, 8'h2C, 32'h3F, 4'hF);
      apb(1'b1, 8'h30, 32'h0, 4'hF);
      apb(1'b1, 8'h0C, 32'hFFFFFFFF, 4'hF);
      rdchk(8'h0C, 32'h3F);
      rdchk(8'h10, 32'h0);
      // Reserved bits written as ones must not stick
      for (int i = 0; i < 4; i++) begin
         apb(1'b1, 8'h14, 32'hFFFFFFFC | i, 4'hF);
         wait_done();
         chk("ctrl", rd, 32'h80000000 | i);
         chk("sel", resource_select, i);
         rdchk(8'(8'h40 + 4 * i), 32'h3F);
         chk("res", resource_values[i*32 +: 32], 32'h3F);
      end
      // Stale compare value: resource must keep its contents
      apb(1'b1, 8'h2C, 32'h7, 4'hF);
      apb(1'b1, 8'h14, 32'h0, 4'hF);
      wait_done();
      rdchk(8'h40, 32'h3F);
      apb(1'b1, 8'h14, 32'h1, 4'h0);
      rdchk(8'h14, 32'h0);
      rdchk(8'h24, 32'h1);
      chk("irq masked", irq, 32'h0);
      apb(1'b1, 8'h28, 32'h1, 4'hF);
      rdchk(8'h28, 32'h1);
      chk("irq on", irq, 32'h1);
      apb(1'b1, 8'h24, 32'h1, 4'hF);
      rdchk(8'h24, 32'h0);
      chk("irq off", irq, 32'h0);
      // Frozen clock enable: a control write must leave no trace
      clk_en <= 1'b0;
      apb(1'b1, 8'h14, 32'h3, 4'hF);
      clk_en <= 1'b1;
      rdchk(8'h14, 32'h0);
      chk("sel frozen", resource_select, 32'h0);
      rdchk(8'hF0, 32'h0);
      chk("slverr", err, 32'h1);
      print_verdict();
   end
endmodule
